/* File: hdl/rcw_reset_ctrl.sv */
// Reset source combiner, cause flags, brown-out filter and watchdog.
//
// Implementation choices: the address-and-strobe port and the register offsets.

// Notes on behaviour
// - Reset pin low forces reset asynchronously, even without a clock.
// - After the pin rises, start-up delay runs before reset releases.
// - Level fuse 111 disables brown-out; 110,101,100,011 levels; rest reserved.
// - Qualified brown-out asserts reset at once, no delay counter.
// - After supply recovers, reset holds for the full start-up delay.
// - Supply dips shorter than the brown-out minimum pulse are ignored.
// - Watchdog timeout makes a reset pulse of exactly one clock.
// - Delay counting starts as the watchdog pulse falls.
// - Bit 4 flags test-port reset; power-on or written zero clears.
// - Bit 3 flags watchdog reset; power-on or written zero clears.
// - Bit 2 flags brown-out reset; power-on or written zero clears.
// - Bit 1 flags pin reset; power-on or written zero clears.
// - Bit 0 flags power-on; only a written zero clears it.
// - Bandgap on only while brown-out enabled or bandgap select set.
// - Watchdog counts ticks of its own 1 MHz oscillator; the code makes the tick by dividing sys_clk by WDT_DIV.
// - Watchdog count cleared by restart, when disabled, and by reset.
// - Eight periods; expiry without restart resets the chip.
// - Two fuses give safety level 0, 1 or 2; level 2 always on.
// - Enabling always immediate; period changes timed except level 0.
// - Change enable self-clears four cycles after being written.
// - Period code 000 gives 16K ticks, doubling up to 2048K.
// - Delay starts once all sources idle; length from clock fuses.
module rcw_reset_ctrl
    import rcw_pkg::*;
#(
    parameter logic [21:0] WDT_BASE_TICKS = WDT_BASE_DEF,
    parameter logic [23:0] STARTUP_SHORT  = STARTUP_SHORT_DEF,
    parameter logic [23:0] STARTUP_LONG   = STARTUP_LONG_DEF
) (
    // Clock and power-on reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Register port
    input  wire rcw_bus_t   bus,
    output logic [7:0]      rdata,
    // Reset sources and supply monitor
    input  wire logic       reset_pin_n,
    input  wire logic       supply_low,
    input  wire logic       test_port_reset,
    input  wire logic       watchdog_restart_instruction,
    // Fuses
    input  wire rcw_fuses_t fuses,
    // Outputs to the chip
    output logic            core_reset,
    output logic            bandgap_enable,
    output logic            brownout_enable
);

    // Safety level from the two watchdog fuses (1 = programmed)
    function automatic rcw_level_t rcw_safety_level(input rcw_fuses_t f);
        if (f.always_on) begin
            return RCW_LVL2;
        end else if (f.compat) begin
            return RCW_LVL0;
        end else begin
            return RCW_LVL1;
        end
    endfunction : rcw_safety_level

    // Brown-out enable from level code; reserved codes leave it off
    function automatic logic rcw_bod_on(input logic [2:0] code);
        return (code == BOD_L110) || (code == BOD_L101) ||
               (code == BOD_L100) || (code == BOD_L011);
    endfunction : rcw_bod_on

    rcw_state_t  st;
    rcw_state_t  next_st;
    logic        pin_meta;
    logic        pin_sync;
    logic        next_core_reset;
    logic        sources;
    logic        tick;
    logic        lvl0;
    logic        lvl2;
    logic        bod_en;
    logic [21:0] per_ticks;
    logic [23:0] timeout;

    // Pin reset catcher: asserts without clock, releases through two flops
    always_ff @(posedge sys_clk or posedge rst or negedge reset_pin_n) begin
        if (rst) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else if (!reset_pin_n) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            pin_meta <= 1'b0;
            pin_sync <= pin_meta;
        end
    end

    // Chip reset output, also forced directly by the pin
    always_ff @(posedge sys_clk or posedge rst or negedge reset_pin_n) begin
        if (rst) begin
            core_reset <= 1'b1;
        end else if (!reset_pin_n) begin
            core_reset <= 1'b1;
        end else begin
            core_reset <= next_core_reset;
        end
    end

    always_comb begin
        lvl0      = (rcw_safety_level(fuses) == RCW_LVL0);
        lvl2      = (rcw_safety_level(fuses) == RCW_LVL2);
        bod_en    = rcw_bod_on(fuses.bod_level);
        per_ticks = WDT_BASE_TICKS << st.wdt_per;
        timeout   = fuses.clk_sel[0] ? STARTUP_LONG : STARTUP_SHORT;
        tick      = (st.osc_div == WDT_DIV - 6'h01);
        sources   = pin_sync | st.bod_act | st.tst_sync | st.wdt_pulse;

        next_st           = st;
        next_st.rdata     = 8'h00;
        next_st.wdt_pulse = 1'b0;

        // Input synchronisers
        next_st.sup_meta = supply_low;
        next_st.sup_sync = st.sup_meta;
        next_st.tst_meta = test_port_reset;
        next_st.tst_sync = st.tst_meta;

        // Brown-out pulse filter
        if (bod_en && st.sup_sync) begin
            if (st.bod_cnt == BOD_MIN_CYC) begin
                next_st.bod_act = 1'b1;
            end else begin
                next_st.bod_cnt = st.bod_cnt + 7'h01;
            end
        end else begin
            next_st.bod_cnt = 7'h00;
            next_st.bod_act = 1'b0;
        end

        // Hold-off sequence
        case (st.phase)
            RCW_HOLD: begin
                if (sources) begin
                    next_st.dly_cnt = 24'h000000;
                end else if (st.dly_cnt == timeout - 24'h000001) begin
                    next_st.phase   = RCW_RUN;
                    next_st.dly_cnt = 24'h000000;
                end else begin
                    next_st.dly_cnt = st.dly_cnt + 24'h000001;
                end
            end
            RCW_RUN: begin
                if (sources) begin
                    next_st.phase   = RCW_HOLD;
                    next_st.dly_cnt = 24'h000000;
                end
            end
            default: begin
                next_st.phase = RCW_HOLD;
            end
        endcase

        // Watchdog oscillator tick
        next_st.osc_div = tick ? 6'h00 : st.osc_div + 6'h01;

        // Watchdog counter
        if (st.phase == RCW_HOLD || !st.wdt_en ||
            watchdog_restart_instruction) begin
            next_st.wdt_cnt = 22'h000000;
        end else if (tick) begin
            if (st.wdt_cnt == per_ticks - 22'h000001) begin
                next_st.wdt_pulse = 1'b1;
                next_st.wdt_cnt   = 22'h000000;
            end else begin
                next_st.wdt_cnt = st.wdt_cnt + 22'h000001;
            end
        end

        // Change-enable window
        if (st.wdt_ce) begin
            if (st.ce_cnt == 3'h1) begin
                next_st.wdt_ce = 1'b0;
                next_st.ce_cnt = 3'h0;
            end else begin
                next_st.ce_cnt = st.ce_cnt - 3'h1;
            end
        end

        // Register writes
        if (bus.wr) begin
            if (bus.addr == REG_CAUSE) begin
                next_st.cause = st.cause & bus.wdata & CAUSE_MASK;
            end else if (bus.addr == REG_WDT) begin
                if (bus.wdata[WDT_CE_BIT]) begin
                    next_st.wdt_ce = 1'b1;
                    next_st.ce_cnt = CE_WINDOW;
                end
                if (bus.wdata[WDT_EN_BIT]) begin
                    next_st.wdt_en = 1'b1;
                end else if (st.wdt_ce && !lvl2) begin
                    next_st.wdt_en = 1'b0;
                end
                if (lvl0 || st.wdt_ce) begin
                    next_st.wdt_per = bus.wdata[2:0];
                end
            end else if (bus.addr == REG_CMP) begin
                next_st.cmp_bg = bus.wdata[CMP_BG_BIT];
            end
        end

        // Level 2 keeps the watchdog running
        if (lvl2) begin
            next_st.wdt_en = 1'b1;
        end

        // Chip reset returns control registers to initial values
        if (st.phase == RCW_HOLD) begin
            next_st.wdt_en  = lvl2;
            next_st.wdt_ce  = 1'b0;
            next_st.ce_cnt  = 3'h0;
            next_st.wdt_per = 3'h0;
            next_st.cmp_bg  = 1'b0;
        end

        // Cause flags; a set beats a same-cycle clear
        if (pin_sync) begin
            next_st.cause[CAUSE_PIN] = 1'b1;
        end
        if (st.bod_act) begin
            next_st.cause[CAUSE_BOD] = 1'b1;
        end
        if (st.wdt_pulse) begin
            next_st.cause[CAUSE_WDT] = 1'b1;
        end
        if (st.tst_sync) begin
            next_st.cause[CAUSE_TST] = 1'b1;
        end

        // Analog enables
        next_st.bod_en = bod_en;
        next_st.bg_en  = bod_en | st.cmp_bg;

        // Register reads, data in the following cycle only
        if (bus.rd) begin
            if (bus.addr == REG_CAUSE) begin
                next_st.rdata = st.cause & CAUSE_MASK;
            end else if (bus.addr == REG_WDT) begin
                next_st.rdata = {3'h0, st.wdt_ce, st.wdt_en, st.wdt_per};
            end else if (bus.addr == REG_CMP) begin
                next_st.rdata = {1'b0, st.cmp_bg, 6'h00};
            end else begin
                next_st.rdata = 8'h00;
            end
        end

        next_core_reset = (next_st.phase == RCW_HOLD);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= RCW_STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    assign rdata           = st.rdata;
    assign bandgap_enable  = st.bg_en;
    assign brownout_enable = st.bod_en;

endmodule : rcw_reset_ctrl

/* File: include/rcw_pkg.sv */
// Package for the reset controller and watchdog: constants, carriers, state.
package rcw_pkg;

    // Clock and timing
    localparam int          SYS_CLK_MHZ      = 40;
    localparam int          BOD_MIN_PULSE_NS = 2000;
    localparam int          BOD_MIN_CYC_I    =
        (BOD_MIN_PULSE_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam logic [6:0]  BOD_MIN_CYC      = 7'(BOD_MIN_CYC_I);
    localparam int          WDT_OSC_KHZ      = 1000;
    localparam int          WDT_DIV_I        = SYS_CLK_MHZ * 1000 / WDT_OSC_KHZ;
    localparam logic [5:0]  WDT_DIV          = 6'(WDT_DIV_I);
    localparam logic [2:0]  CE_WINDOW        = 3'h4;

    // Default counts, overridable at the top
    localparam logic [21:0] WDT_BASE_DEF      = 22'h004000;
    localparam logic [23:0] STARTUP_SHORT_DEF = 24'h0186A0;
    localparam logic [23:0] STARTUP_LONG_DEF  = 24'h0F4240;

    // Brown-out level codes
    localparam logic [2:0]  BOD_OFF  = 3'h7;
    localparam logic [2:0]  BOD_L110 = 3'h6;
    localparam logic [2:0]  BOD_L101 = 3'h5;
    localparam logic [2:0]  BOD_L100 = 3'h4;
    localparam logic [2:0]  BOD_L011 = 3'h3;

    // Register offsets
    localparam logic [7:0]  REG_CAUSE = 8'h00;
    localparam logic [7:0]  REG_WDT   = 8'h01;
    localparam logic [7:0]  REG_CMP   = 8'h02;

    // Field positions
    localparam int          CAUSE_POR  = 0;
    localparam int          CAUSE_PIN  = 1;
    localparam int          CAUSE_BOD  = 2;
    localparam int          CAUSE_WDT  = 3;
    localparam int          CAUSE_TST  = 4;
    localparam logic [7:0]  CAUSE_MASK = 8'h1F;
    localparam logic [7:0]  CAUSE_RST  = 8'h01;
    localparam int          WDT_CE_BIT = 4;
    localparam int          WDT_EN_BIT = 3;
    localparam int          CMP_BG_BIT = 6;

    typedef enum logic [1:0] {
        RCW_LVL0 = 2'b00,
        RCW_LVL1 = 2'b01,
        RCW_LVL2 = 2'b10
    } rcw_level_t;

    typedef enum logic {
        RCW_RUN  = 1'b0,
        RCW_HOLD = 1'b1
    } rcw_phase_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rcw_bus_t;

    typedef struct packed {
        logic [2:0] bod_level;
        logic       compat;
        logic       always_on;
        logic [3:0] clk_sel;
    } rcw_fuses_t;

    typedef struct packed {
        rcw_phase_t  phase;
        logic [23:0] dly_cnt;
        logic [7:0]  cause;
        logic        wdt_en;
        logic        wdt_ce;
        logic [2:0]  ce_cnt;
        logic [2:0]  wdt_per;
        logic        cmp_bg;
        logic [21:0] wdt_cnt;
        logic [5:0]  osc_div;
        logic        wdt_pulse;
        logic [6:0]  bod_cnt;
        logic        bod_act;
        logic        sup_meta;
        logic        sup_sync;
        logic        tst_meta;
        logic        tst_sync;
        logic        bg_en;
        logic        bod_en;
        logic [7:0]  rdata;
    } rcw_state_t;

    localparam rcw_state_t RCW_STATE_RST = '{
        phase:   RCW_HOLD,
        dly_cnt: 24'h000000,
        cause:   CAUSE_RST,
        wdt_en:  1'b0,
        wdt_ce:  1'b0,
        ce_cnt:  3'h0,
        wdt_per: 3'h0,
        cmp_bg:  1'b0,
        wdt_cnt: 22'h000000,
        osc_div: 6'h00,
        wdt_pulse: 1'b0,
        bod_cnt: 7'h00,
        bod_act: 1'b0,
        sup_meta: 1'b0,
        sup_sync: 1'b0,
        tst_meta: 1'b0,
        tst_sync: 1'b0,
        bg_en:   1'b0,
        bod_en:  1'b0,
        rdata:   8'h00
    };

endpackage : rcw_pkg

/* File: verification/rcw_reset_ctrl_monitor.sv */
// Checker for reset controller and watchdog port behaviour.
module rcw_reset_ctrl_monitor
    import rcw_pkg::*;
(
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst,
    // Register port
    input wire rcw_bus_t   bus,
    input wire logic [7:0] rdata,
    // Sources and fuses
    input wire logic       reset_pin_n,
    input wire logic       supply_low,
    input wire logic       test_port_reset,
    input wire logic       watchdog_restart_instruction,
    input wire rcw_fuses_t fuses,
    // Outputs
    input wire logic       core_reset,
    input wire logic       bandgap_enable,
    input wire logic       brownout_enable
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [7:0] low_cnt;
    logic       por;

    // Consecutive low-supply cycles and power-on flag shadow
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            low_cnt <= 8'h00;
            por     <= 1'b1;
        end else begin
            if (!supply_low) begin
                low_cnt <= 8'h00;
            end else if (low_cnt != 8'hFF) begin
                low_cnt <= low_cnt + 8'h01;
            end
            if (bus.wr && bus.addr == REG_CAUSE && !bus.wdata[0]) begin
                por <= 1'b0;
            end
        end
    end

    sequence hold_off;
        core_reset [*8];
    endsequence

    chk_pin_async:
        assert property (!reset_pin_n |-> core_reset)
        else $error("pin low without reset");
    chk_pin_release:
        assert property ($rose(reset_pin_n) && !supply_low && !test_port_reset
            |-> hold_off ##[1:24] !core_reset)
        else $error("pin release timing wrong");
    chk_hold_min:
        assert property ($rose(core_reset) |-> hold_off)
        else $error("reset hold too short");
    chk_bod_fires:
        assert property (low_cnt == 8'h5A && brownout_enable |-> core_reset)
        else $error("brown-out not reset");
    chk_bod_filter:
        assert property (brownout_enable && !core_reset && reset_pin_n
            && !test_port_reset && $rose(supply_low) |-> !core_reset [*8])
        else $error("short dip reset");
    chk_bod_code:
        assert property (!$past(rst) |-> brownout_enable ==
            (fuses.bod_level inside {[3'h3:3'h6]}))
        else $error("brown-out enable wrong");
    chk_bandgap_on:
        assert property (brownout_enable |-> bandgap_enable)
        else $error("bandgap off with brown-out");
    chk_por_flag:
        assert property ($past(bus.rd && bus.addr == REG_CAUSE && por)
            |-> rdata[0])
        else $error("power-on flag lost");
endmodule : rcw_reset_ctrl_monitor

bind rcw_reset_ctrl rcw_reset_ctrl_monitor mon (
    .sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata),
    .reset_pin_n(reset_pin_n), .supply_low(supply_low),
    .test_port_reset(test_port_reset),
    .watchdog_restart_instruction(watchdog_restart_instruction),
    .fuses(fuses), .core_reset(core_reset),
    .bandgap_enable(bandgap_enable), .brownout_enable(brownout_enable)
);

/* File: verification/rcw_reset_ctrl_tb.sv */
// Self-checking bench for the reset controller and watchdog.
module rcw_reset_ctrl_tb
    import rcw_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       sys_clk = 1'b0;
    logic       rst     = 1'b1;
    rcw_bus_t   bus     = '0;
    rcw_fuses_t fuses   = '0;
    logic       tst     = 1'b0;
    logic       rsti    = 1'b0;
    logic       rd_q    = 1'b0;
    logic [7:0] rdata;
    logic       core_reset;
    logic       bandgap_enable;
    logic       brownout_enable;
    logic       pin_n;
    logic       sup;
    logic [7:0] exp_q[$];
    int         miscompares     = 0;
    int         samples_checked = 0;
    int         n;
    // Reference start-up, 70 us at 25 ns
    localparam int BG_START_CYC = 2800;

    always #12.5 sys_clk = ~sys_clk;

    rcw_supply_model p (.sys_clk(sys_clk), .reset_pin_n(pin_n),
        .supply_low(sup));
    rcw_reset_ctrl #(.WDT_BASE_TICKS(22'h000004),
        .STARTUP_SHORT(24'h000008), .STARTUP_LONG(24'h000010)) uut (
        .sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata),
        .reset_pin_n(pin_n), .supply_low(sup), .test_port_reset(tst),
        .watchdog_restart_instruction(rsti), .fuses(fuses),
        .core_reset(core_reset), .bandgap_enable(bandgap_enable),
        .brownout_enable(brownout_enable));

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic end_of_test;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus <= '0;
        @(posedge sys_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus <= '0;
        @(posedge sys_clk);
    endtask : rd

    // Counts cycles until reset drops, ends at a falling edge
    task automatic rel(output int c);
        c = 0;
        do begin
            @(negedge sys_clk);
            c++;
        end while (core_reset !== 1'b0 && c < 400);
    endtask : rel

    task automatic boot(input rcw_fuses_t f);
        rst   <= 1'b1;
        fuses <= f;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rel(n);
    endtask : boot

    // Read results stand one cycle after the strobe
    always @(posedge sys_clk) rd_q <= bus.rd;
    always @(negedge sys_clk) if (rd_q) cmp(rdata, exp_q.pop_front());

    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        end_of_test();
    end

    initial begin
        n = $urandom(32'hA1FFAA2A);
        for (int i = 0; i < 8; i++) begin
            boot('{3'(i), 1'b0, 1'b0, 4'(i)});
            cmp(8'(n >= 8 + 8 * (i % 2) && n <= 12 + 8 * (i % 2)), 8'h01);
            cmp({6'h0, brownout_enable, bandgap_enable},
                {6'h0, {2{i inside {[3:6]}}}});
            @(posedge sys_clk);
        end
        for (int j = 0; j < 2; j++) begin
            wr(REG_CMP, j ? 8'h00 : 8'h40);
            if (j == 0) begin
                repeat (BG_START_CYC) @(posedge sys_clk);
            end
            @(negedge sys_clk);
            cmp({7'h0, bandgap_enable}, j ? 8'h00 : 8'h01);
            @(posedge sys_clk);
        end
        boot('{3'h6, 1'b0, 1'b0, 4'h0});
        @(posedge sys_clk);
        rd(REG_CAUSE, 8'h01);
        wr(REG_CAUSE, 8'h00);
        rd(REG_CAUSE, 8'h00);
        rd(8'h03 + 8'($urandom % 253), 8'h00);
        p.pin_pulse(1 + $urandom % 4);
        rel(n);
        cmp(8'(n >= 8 && n <= 16), 8'h01);
        @(posedge sys_clk);
        rd(REG_CAUSE, 8'h02);
        wr(REG_CAUSE, 8'h00);
        p.dip(10 + $urandom % 30);
        @(negedge sys_clk);
        cmp({7'h0, core_reset}, 8'h00);
        p.dip(100);
        @(negedge sys_clk);
        cmp({7'h0, core_reset}, 8'h01);
        rel(n);
        cmp(8'(n >= 8), 8'h01);
        @(posedge sys_clk);
        rd(REG_CAUSE, 8'h04);
        wr(REG_CAUSE, 8'h00);
        tst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        tst <= 1'b0;
        rel(n);
        @(posedge sys_clk);
        rd(REG_CAUSE, 8'h10);
        wr(REG_CAUSE, 8'h00);
        wr(REG_WDT, 8'h09);
        rd(REG_WDT, 8'h08);
        repeat (6) begin
            repeat (100) @(posedge sys_clk);
            rsti <= 1'b1;
            @(posedge sys_clk);
            rsti <= 1'b0;
        end
        n = 0;
        while (core_reset !== 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        cmp(8'(n >= 118 && n <= 165), 8'h01);
        rel(n);
        cmp(8'(n >= 8), 8'h01);
        @(posedge sys_clk);
        rd(REG_CAUSE, 8'h08);
        rd(REG_WDT, 8'h00);
        wr(REG_WDT, 8'h08);
        wr(REG_WDT, 8'h18);
        wr(REG_WDT, 8'h19);
        repeat (6) @(posedge sys_clk);
        rd(REG_WDT, 8'h09);
        wr(REG_WDT, 8'h18);
        repeat (6) @(posedge sys_clk);
        wr(REG_WDT, 8'h00);
        rd(REG_WDT, 8'h09);
        wr(REG_WDT, 8'h18);
        wr(REG_WDT, 8'h00);
        repeat (4) @(posedge sys_clk);
        rd(REG_WDT, 8'h00);
        boot('{3'h7, 1'b0, 1'b1, 4'h0});
        @(posedge sys_clk);
        wr(REG_WDT, 8'h18);
        wr(REG_WDT, 8'h00);
        repeat (4) @(posedge sys_clk);
        rd(REG_WDT, 8'h08);
        boot('{3'h7, 1'b1, 1'b0, 4'h0});
        @(posedge sys_clk);
        wr(REG_WDT, 8'h0B);
        rd(REG_WDT, 8'h0B);
        repeat (2) @(posedge sys_clk);
        end_of_test();
    end
endmodule : rcw_reset_ctrl_tb

/* File: verification/rcw_supply_model.sv */
// Model of the reset pin circuit and supply comparator.
module rcw_supply_model
(
    // Clock
    input  wire logic sys_clk,
    // Pin and comparator
    output logic      reset_pin_n,
    output logic      supply_low
);
    timeunit 1ns;
    timeprecision 100ps;
    // Pin pulled up, supply good
    initial begin
        reset_pin_n = 1'b1;
        supply_low  = 1'b0;
    end
    task automatic pin_pulse(input int n);
        @(posedge sys_clk);
        reset_pin_n <= 1'b0;
        repeat (n) @(posedge sys_clk);
        reset_pin_n <= 1'b1;
    endtask : pin_pulse
    task automatic dip(input int n);
        @(posedge sys_clk);
        supply_low <= 1'b1;
        repeat (n) @(posedge sys_clk);
        supply_low <= 1'b0;
    endtask : dip
endmodule : rcw_supply_model
